// ===== hdl/wcl_load_ctrl.sv
module wcl_load_ctrl #(
   parameter int REST_TICKS_PER_SEC = 100_000
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [10:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [7:0] adc1_sample,
   input wire logic [7:0] adc2_sample,
   input wire logic adc_valid,
   input wire logic [1:0] fet_voltage_ok,
   input wire logic [1:0] filtered_channel_output,
   input wire logic [1:0] input_rise,
   output logic [1:0] load_on,
   output logic [7:0] pulse_code,
   output logic [5:0] hold_code,
   output logic [1:0] pulse_active
);
   import wcl_pkg::*;

   // ****************************************************************
   // Pin synchronisers.
   // ****************************************************************
   logic [5:0] sync1_q;
   logic [5:0] sync2_q;
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= 6'h00;
         sync2_q <= 6'h00;
      end else if (clk_en) begin
         sync1_q <= {fet_voltage_ok, filtered_channel_output, input_rise};
         sync2_q <= sync1_q;
      end
   end
   wire [1:0] fet_ok_s = sync2_q[5:4];
   wire [1:0] dout_s = sync2_q[3:2];
   wire [1:0] rise_s = sync2_q[1:0];

   // ****************************************************************
   // Registers.
   // ****************************************************************
   logic [15:0] egy_ctrl_q, egy_ctrl_d, load_en_q, load_en_d;
   logic [15:0] dur_q, dur_d, plev_q, plev_d, hlev_q, hlev_d;
   logic [15:0] lctrl_q, lctrl_d, rthr_q, rthr_d, limit_q, limit_d;
   logic [15:0] rdata_d;
   logic [15:0] acc_q [2];
   wcl_state_t st_q [2];

   // Register writes decode into shadow next values.
   always_comb begin
      egy_ctrl_d = egy_ctrl_q;
      load_en_d = load_en_q;
      dur_d = dur_q;
      plev_d = plev_q;
      hlev_d = hlev_q;
      lctrl_d = lctrl_q;
      rthr_d = rthr_q;
      limit_d = limit_q;
      if (reg_wr) begin
         case (reg_addr)
            ADDR_ENERGY_CTRL: egy_ctrl_d = reg_wdata;
            ADDR_LOAD_ENABLE: load_en_d = reg_wdata;
            ADDR_PULSE_DUR: dur_d = {4'h0, reg_wdata[11:0]};
            ADDR_PULSE_LEVEL: plev_d = {8'h00, reg_wdata[7:0]};
            ADDR_HOLD_LEVEL: hlev_d = {10'h000, reg_wdata[5:0]};
            ADDR_LOAD_CTRL: lctrl_d = {15'h0000, reg_wdata[IDLE_MODE_BIT]};
            ADDR_RISE_TRIGGER_LEVEL: rthr_d = {8'h00, reg_wdata[7:0]};
            ADDR_ENERGY_LIMIT: limit_d = reg_wdata;
            default: ;
         endcase
      end
   end

   // Read mux; unmapped addresses read as zero.
   always_comb begin
      rdata_d = reg_rdata;
      if (reg_rd) begin
         case (reg_addr)
            ADDR_ENERGY_CTRL: rdata_d = egy_ctrl_q;
            ADDR_LOAD_ENABLE: rdata_d = load_en_q;
            ADDR_PULSE_DUR: rdata_d = dur_q;
            ADDR_PULSE_LEVEL: rdata_d = plev_q;
            ADDR_HOLD_LEVEL: rdata_d = hlev_q;
            ADDR_LOAD_CTRL: rdata_d = lctrl_q;
            ADDR_RISE_TRIGGER_LEVEL: rdata_d = rthr_q;
            ADDR_ENERGY_LIMIT: rdata_d = limit_q;
            ADDR_ENERGY_ACC1: rdata_d = acc_q[0];
            ADDR_ENERGY_ACC2: rdata_d = acc_q[1];
            ADDR_LOAD_STATUS: rdata_d = {8'h00, 2'b00, st_q[1], 2'b00,
                                         st_q[0]};
            default: rdata_d = 16'h0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         egy_ctrl_q <= RST_REG;
         load_en_q <= RST_REG;
         dur_q <= RST_REG;
         plev_q <= RST_REG;
         hlev_q <= RST_REG;
         lctrl_q <= RST_REG;
         rthr_q <= RST_REG;
         limit_q <= RST_LIMIT;
         reg_rdata <= RST_REG;
      end else if (clk_en) begin
         egy_ctrl_q <= egy_ctrl_d;
         load_en_q <= load_en_d;
         dur_q <= dur_d;
         plev_q <= plev_d;
         hlev_q <= hlev_d;
         lctrl_q <= lctrl_d;
         rthr_q <= rthr_d;
         limit_q <= limit_d;
         reg_rdata <= rdata_d;
      end
   end

   // ****************************************************************
   // Time base: 10 us tick and drain step.
   // ****************************************************************
   logic [10:0] tick_cnt_q, tick_cnt_d;
   logic [2:0] drain_cnt_q, drain_cnt_d;
   logic tick, drain_step;
   logic [2:0] drain_max;

   // Tick count per drain step is 1, 2, 4 or 8 ticks.
   always_comb begin
      tick = (tick_cnt_q == 11'(TICK_CYC - 1));
      tick_cnt_d = tick ? 11'h000 : tick_cnt_q + 11'h001;
      case (egy_ctrl_q[DRAIN_IVL_HI:DRAIN_IVL_LO])
         2'b00: drain_max = 3'h0;
         2'b01: drain_max = 3'h1;
         2'b10: drain_max = 3'h3;
         default: drain_max = 3'h7;
      endcase
      drain_step = tick && (drain_cnt_q >= drain_max);
      drain_cnt_d = drain_cnt_q;
      if (tick) begin
         drain_cnt_d = drain_step ? 3'h0 : drain_cnt_q + 3'h1;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_cnt_q <= 11'h000;
         drain_cnt_q <= 3'h0;
      end else if (clk_en) begin
         tick_cnt_q <= tick_cnt_d;
         drain_cnt_q <= drain_cnt_d;
      end
   end

   // Increment for one 10 us pulse tick, with overvoltage scaling.
   function automatic logic [15:0] pulse_incr(input logic [7:0] adc,
                                              input logic [1:0] ov);
      logic [15:0] base;
      base = {8'h00, adc} >> ACC_SHIFT;
      if (adc == 8'hff) begin
         case (ov)
            2'b00: pulse_incr = base;
            2'b01: pulse_incr = base << 2;
            2'b10: pulse_incr = base << 3;
            default: pulse_incr = base << 4;
         endcase
      end else begin
         pulse_incr = base;
      end
   endfunction : pulse_incr

   // ****************************************************************
   // Per-channel load sequencer and energy monitor.
   // ****************************************************************
   wcl_state_t st_d [2];
   logic [15:0] acc_d [2];
   logic [11:0] ptime_q [2], ptime_d [2];
   logic [3:0] rest_q [2], rest_d [2];
   // Per-channel sub-second count, so a rest always lasts whole seconds.
   logic [16:0] rsub_q [2], rsub_d [2];
   logic [1:0] load_on_d, pulse_d;
   logic load_enabled, low_idle;
   logic [3:0] rest_sec;
   logic [7:0] adc_v [2];
   logic [16:0] sum;

   assign adc_v[0] = adc1_sample;
   assign adc_v[1] = adc2_sample;

   always_comb begin
      load_enabled = (load_en_q[LOAD_EN_HI:LOAD_EN_LO] != 2'b00);
      low_idle = !lctrl_q[IDLE_MODE_BIT];
      rest_sec = egy_ctrl_q[REST_HI:REST_LO];
      sum = 17'h00000;
      for (int c = 0; c < 2; c++) begin
         st_d[c] = st_q[c];
         acc_d[c] = acc_q[c];
         ptime_d[c] = ptime_q[c];
         rest_d[c] = rest_q[c];
         rsub_d[c] = rsub_q[c];
         case (st_q[c])
            ST_IDLE, ST_HOLD: begin
               if (drain_step) begin
                  acc_d[c] = (acc_q[c] > {8'h00, egy_ctrl_q[15:8]}) ?
                     acc_q[c] - {8'h00, egy_ctrl_q[DRAIN_AMT_HI:DRAIN_AMT_LO]}
                     : 16'h0000;
               end
               if (!rise_s[c]) begin
                  st_d[c] = ST_IDLE;
               end else if (st_q[c] == ST_IDLE && load_enabled
                            && !dout_s[c]
                            && ((low_idle && adc_valid
                                 && adc_v[c] >= rthr_q[7:0])
                                || (!low_idle && fet_ok_s[c]))) begin
                  st_d[c] = ST_PULSE;
                  ptime_d[c] = dur_q[11:0];
               end else if (st_q[c] == ST_IDLE && load_enabled) begin
                  st_d[c] = ST_IDLE;
               end
            end
            ST_PULSE: begin
               if (tick) begin
                  sum = {1'b0, acc_q[c]} +
                        {1'b0, pulse_incr(adc_v[c], egy_ctrl_q[OV_HI:OV_LO])};
                  acc_d[c] = sum[16] ? 16'hffff : sum[15:0];
                  if (rest_sec != 4'h0 && acc_d[c] >= limit_q) begin
                     st_d[c] = ST_REST;
                     rest_d[c] = rest_sec;
                     rsub_d[c] = 17'(REST_TICKS_PER_SEC - 1);
                     acc_d[c] = 16'h0000;
                  end else if (ptime_q[c] <= 12'h001) begin
                     st_d[c] = ST_HOLD;
                  end else begin
                     ptime_d[c] = ptime_q[c] - 12'h001;
                  end
               end
               if (!load_enabled) begin
                  st_d[c] = ST_IDLE;
               end
            end
            ST_REST: begin
               acc_d[c] = 16'h0000;
               if (tick) begin
                  if (rsub_q[c] != 17'h00000) begin
                     rsub_d[c] = rsub_q[c] - 17'h00001;
                  end else begin
                     rsub_d[c] = 17'(REST_TICKS_PER_SEC - 1);
                     rest_d[c] = rest_q[c] - 4'h1;
                     if (rest_q[c] <= 4'h1) begin
                        st_d[c] = ST_HOLD;
                     end
                  end
               end
            end
            default: st_d[c] = ST_IDLE;
         endcase
         if (rest_sec == 4'h0) begin
            acc_d[c] = 16'h0000;
         end
         load_on_d[c] = load_enabled && (st_d[c] != ST_IDLE || rise_s[c]);
         pulse_d[c] = (st_d[c] == ST_PULSE);
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         for (int c = 0; c < 2; c++) begin
            st_q[c] <= ST_IDLE;
            acc_q[c] <= 16'h0000;
            ptime_q[c] <= 12'h000;
            rest_q[c] <= 4'h0;
            rsub_q[c] <= 17'h00000;
         end
         load_on <= 2'b00;
         pulse_active <= 2'b00;
         pulse_code <= 8'h00;
         hold_code <= 6'h00;
      end else if (clk_en) begin
         for (int c = 0; c < 2; c++) begin
            st_q[c] <= st_d[c];
            acc_q[c] <= acc_d[c];
            ptime_q[c] <= ptime_d[c];
            rest_q[c] <= rest_d[c];
            rsub_q[c] <= rsub_d[c];
         end
         load_on <= load_on_d;
         pulse_active <= pulse_d;
         pulse_code <= plev_q[7:0];
         hold_code <= hlev_q[5:0];
      end
   end

   // ****************************************************************
   // Assertions.
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   AST_REST_CLEARS: assert property (
      clk_en && st_q[0] == ST_REST |=> acc_q[0] == 16'h0000)
      else $error("energy not zero during rest");
   AST_DISABLED_NO_PULSE: assert property (
      clk_en && load_en_q[15:14] == 2'b00 |=> !pulse_active[0])
      else $error("pulse while load disabled");
   AST_DOUT_BLOCKS: assert property (
      clk_en && st_q[1] == ST_IDLE && dout_s[1] |=> st_q[1] != ST_PULSE)
      else $error("pulse started while output high");
   AST_NO_REST_ZERO: assert property (
      clk_en && egy_ctrl_q[3:0] == 4'h0 |=> acc_q[0] == 16'h0000)
      else $error("accumulator not held at zero");
   AST_LIMIT_REST: assert property (
      clk_en && st_q[0] == ST_PULSE && tick && load_enabled
      && rest_sec != 4'h0 && acc_d[0] >= limit_q |=> st_q[0] == ST_REST)
      else $error("limit did not start rest");
   AST_PULSE_OUT: assert property (
      clk_en |=> pulse_active[0] == (st_q[0] == ST_PULSE))
      else $error("pulse flag disagrees with state");
   AST_DRAIN: assert property (
      clk_en && st_q[0] == ST_HOLD && rise_s[0] && drain_step
      && egy_ctrl_q[3:0] != 4'h0 && acc_q[0] > 16'h00ff
      |=> acc_q[0] == $past(acc_q[0]) - {8'h00, $past(egy_ctrl_q[15:8])})
      else $error("drain amount wrong");
   AST_HIGH_IDLE: assert property (
      clk_en && st_q[0] == ST_IDLE && load_enabled && !low_idle
      && rise_s[0] && fet_ok_s[0] && !dout_s[0] |=> st_q[0] == ST_PULSE)
      else $error("high idle did not pulse");
   COV_PULSE: cover property (st_q[0] == ST_IDLE ##1 st_q[0] == ST_PULSE);
   COV_HOLD: cover property (st_q[0] == ST_PULSE ##1 st_q[0] == ST_HOLD);
   COV_REST: cover property (st_q[1] == ST_PULSE ##1 st_q[1] == ST_REST);
endmodule : wcl_load_ctrl

// ===== hdl/wcl_pkg.sv
// Notes on behaviour
// - Input turning on gives a timed pulse current, then the hold current.
// - Pulse level is an 8-bit code, bits 7:0, 0.2 mA per step.
// - Pulse duration is a 12-bit code, bits 11:0, 10 us per step.
// - Hold level is a 6-bit code, bits 5:0, 0.1 mA per step.
// - Low idle mode: the pulse starts when the sample reaches the rise level.
// - High idle mode: the pulse starts as soon as the FET sees voltage.
// - A channel starts a pulse only while its filtered output is low.
// - Load enable field 00 disables the load; only residual current flows.
// - Energy reaching the limit stops that channel's pulse for the rest period.
// - A full-scale sample during a pulse scales the increment by 1, 4, 8 or 16.
// - Rest length in seconds is bits 3:0; zero disables rest, clears energy.
// - Outside a pulse the drain amount, bits 15:8, is subtracted each step.
// - Drain interval bits 5:4 select 10, 20, 40 or 80 us.
// - During rest the channel energy accumulator is held at zero.
// - Each channel keeps its own accumulator, limit check and rest timer.
package wcl_pkg;
   // ****************************************************************
   // Register map.
   // ****************************************************************
   localparam logic [10:0] ADDR_ENERGY_CTRL = 11'h015;
   localparam logic [10:0] ADDR_LOAD_ENABLE = 11'h020;
   localparam logic [10:0] ADDR_PULSE_DUR = 11'h021;
   localparam logic [10:0] ADDR_PULSE_LEVEL = 11'h022;
   localparam logic [10:0] ADDR_HOLD_LEVEL = 11'h023;
   localparam logic [10:0] ADDR_LOAD_CTRL = 11'h024;
   localparam logic [10:0] ADDR_RISE_TRIGGER_LEVEL = 11'h025;
   localparam logic [10:0] ADDR_ENERGY_LIMIT = 11'h026;
   localparam logic [10:0] ADDR_ENERGY_ACC1 = 11'h027;
   localparam logic [10:0] ADDR_ENERGY_ACC2 = 11'h028;
   localparam logic [10:0] ADDR_LOAD_STATUS = 11'h029;
   // ****************************************************************
   // Field positions and reset values.
   // ****************************************************************
   localparam int LOAD_EN_HI = 15;
   localparam int LOAD_EN_LO = 14;
   localparam int IDLE_MODE_BIT = 0;
   localparam int OV_HI = 7;
   localparam int OV_LO = 6;
   localparam int DRAIN_AMT_HI = 15;
   localparam int DRAIN_AMT_LO = 8;
   localparam int DRAIN_IVL_HI = 5;
   localparam int DRAIN_IVL_LO = 4;
   localparam int REST_HI = 3;
   localparam int REST_LO = 0;
   localparam logic [15:0] RST_REG = 16'h0000;
   localparam logic [15:0] RST_LIMIT = 16'hffff;
   // ****************************************************************
   // Timing.
   // ****************************************************************
   localparam int CLK_MHZ = 125;
   localparam int TICK_US = 10;
   localparam int TICK_CYC = TICK_US * CLK_MHZ;
   localparam int SEC_TICKS = 100_000;
   localparam int ACC_SHIFT = 7;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_PULSE = 2'b01,
      ST_HOLD = 2'b10,
      ST_REST = 2'b11
   } wcl_state_t;

   typedef struct packed {
      logic pulse;
      logic hold;
      logic rest;
   } wcl_chan_stat_t;
endpackage : wcl_pkg

// ===== verification/wcl_contact_model.sv
module wcl_contact_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic [1:0] contact,
   input wire logic [7:0] level,
   input wire logic [7:0] step,
   input wire logic [1:0] dout_high,
   output logic [7:0] adc1_sample,
   output logic [7:0] adc2_sample,
   output logic adc_valid,
   output logic [1:0] fet_voltage_ok,
   output logic [1:0] filtered_channel_output,
   output logic [1:0] input_rise
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] adc_q [2];
   logic [1:0] cnt_q;

   // ****************************************************************
   // Contact voltage seen by the converter.
   // ****************************************************************
   // The voltage ramps by step each cycle, so a small step is a slow edge.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         adc_q[0] <= 8'h00;
         adc_q[1] <= 8'h00;
         cnt_q <= 2'h0;
      end else begin
         cnt_q <= cnt_q + 2'h1;
         for (int i = 0; i < 2; i++) begin
            if (!contact[i]) begin
               adc_q[i] <= 8'h00;
            end else if (adc_q[i] >= level || level - adc_q[i] <= step) begin
               adc_q[i] <= level;
            end else begin
               adc_q[i] <= adc_q[i] + step;
            end
         end
      end
   end

   // A sample is offered every fourth cycle, like a slow converter.
   assign adc_valid = (cnt_q == 2'h0);
   assign adc1_sample = adc_q[0];
   assign adc2_sample = adc_q[1];
   // The FET sees voltage at once when the contact closes.
   assign fet_voltage_ok = contact;
   assign input_rise = contact;
   // The filtered output follows dout_high at once; no debounce is modelled.
   assign filtered_channel_output = dout_high;
endmodule : wcl_contact_model

// ===== verification/tb.sv
module tb;
   import wcl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [10:0] reg_addr = 11'h000;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [15:0] reg_rdata;
   logic [7:0] adc1_sample, adc2_sample;
   logic adc_valid;
   logic [1:0] fet_ok, dout, rise, load_on, pulse_active;
   logic [7:0] pulse_code;
   logic [5:0] hold_code;
   logic [1:0] contact = 2'b00;
   logic [1:0] dout_high = 2'b00;
   logic [7:0] level = 8'h00;
   logic [7:0] step = 8'h01;
   int error_cnt = 0;
   int cmp_count = 0;
   int n, len;
   logic [15:0] a0, a1, exp_acc;

   // ****************************************************************
   // Clock, design and far side.
   // ****************************************************************
   // Free-running 125 MHz clock.
   always #4 mclk = ~mclk;

   // A short second keeps the rest period inside the run.
   wcl_load_ctrl #(.REST_TICKS_PER_SEC(10)) dut_u (
      .mclk(mclk), .rst_n(rst_n), .clk_en(1'b1), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .adc1_sample(adc1_sample),
      .adc2_sample(adc2_sample), .adc_valid(adc_valid),
      .fet_voltage_ok(fet_ok), .filtered_channel_output(dout),
      .input_rise(rise), .load_on(load_on), .pulse_code(pulse_code),
      .hold_code(hold_code), .pulse_active(pulse_active));

   wcl_contact_model far_u (
      .mclk(mclk), .rst_n(rst_n), .contact(contact), .level(level),
      .step(step), .dout_high(dout_high), .adc1_sample(adc1_sample),
      .adc2_sample(adc2_sample), .adc_valid(adc_valid),
      .fet_voltage_ok(fet_ok), .filtered_channel_output(dout),
      .input_rise(rise));

   // ****************************************************************
   // Tasks.
   // ****************************************************************
   task automatic close_out();
      $display("mismatches=%0d compares=%0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wr(input logic [10:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr

   // Read data appears in the cycle after the strobe and holds until the next read.
   task automatic rdchk(input logic [10:0] a, input logic [15:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask : rdchk

   task automatic rd(input logic [10:0] a, output logic [15:0] v);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask : rd

   // Every wait is bounded; running out ends the run as a failure.
   task automatic wait_st(input int ch, input logic v, input int bound,
                          output int cnt);
      cnt = 0;
      while (pulse_active[ch] !== v) begin
         @(posedge mclk);
         #1;
         cnt++;
         if (cnt > bound) begin
            error_cnt++;
            close_out();
         end
      end
   endtask : wait_st

   // Opens the contact, then closes it and times the pulse.
   task automatic pulse(input int ch, output int dly, output int plen);
      @(posedge mclk);
      contact <= 2'b00;
      repeat (8) @(posedge mclk);
      contact[ch] <= 1'b1;
      wait_st(ch, 1'b1, 5000, dly);
      #1;
      chk({8'h00, pulse_code}, 16'h00c8);
      wait_st(ch, 1'b0, 20 * TICK_CYC, plen);
   endtask : pulse

   // ****************************************************************
   // Main sequence.
   // ****************************************************************
   initial begin
      repeat (16) @(posedge mclk);
      rst_n <= 1'b1;
      rdchk(ADDR_LOAD_ENABLE, RST_REG);
      rdchk(ADDR_ENERGY_LIMIT, RST_LIMIT);
      rdchk(ADDR_LOAD_CTRL, RST_REG);
      rdchk(11'h7ff, 16'h0000);
      chk({14'h0000, load_on}, 16'h0000);
      wr(ADDR_PULSE_LEVEL, 16'h00c8);
      rdchk(ADDR_PULSE_LEVEL, 16'h00c8);
      wr(ADDR_HOLD_LEVEL, 16'h00ff);
      rdchk(ADDR_HOLD_LEVEL, 16'h003f);
      wr(ADDR_PULSE_DUR, 16'hf002);
      rdchk(ADDR_PULSE_DUR, 16'h0002);
      wr(ADDR_ENERGY_CTRL, 16'h0001);
      wr(ADDR_RISE_TRIGGER_LEVEL, 16'h0080);
      // A closed contact with the load disabled draws no pulse.
      level <= 8'hc0;
      contact <= 2'b01;
      repeat (3000) @(posedge mclk);
      chk({14'h0000, pulse_active}, 16'h0000);
      chk({14'h0000, load_on}, 16'h0000);
      wr(ADDR_LOAD_ENABLE, 16'hc000);
      // Slow edge in low idle: the pulse waits for the rise level.
      pulse(0, n, len);
      chk(16'(n >= 128), 16'h0001);
      chk(16'(len > TICK_CYC && len <= 2 * TICK_CYC + 4), 16'h0001);
      #1;
      chk({10'h000, hold_code}, 16'h003f);
      chk({15'h0000, load_on[0]}, 16'h0001);
      rdchk(ADDR_ENERGY_ACC1, 16'h0002);
      rdchk(ADDR_ENERGY_ACC2, 16'h0000);
      // A high filtered output blocks the pulse.
      @(posedge mclk);
      dout_high <= 2'b01;
      contact <= 2'b00;
      repeat (8) @(posedge mclk);
      contact <= 2'b01;
      repeat (3000) @(posedge mclk);
      chk({14'h0000, pulse_active}, 16'h0000);
      // Open the contact in the same cycle, so the released output starts no pulse.
      contact <= 2'b00;
      dout_high <= 2'b00;
      // High idle starts at once with no voltage on the converter.
      wr(ADDR_LOAD_CTRL, 16'h0001);
      wr(ADDR_PULSE_DUR, 16'h0001);
      level <= 8'h00;
      pulse(0, n, len);
      chk(16'(n <= 8), 16'h0001);
      chk(16'(len <= TICK_CYC + 4), 16'h0001);
      wr(ADDR_LOAD_CTRL, 16'h0000);
      // Full-scale samples scale the increment by each multiplier.
      level <= 8'hff;
      step <= 8'hff;
      exp_acc = 16'h0002;
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_ENERGY_CTRL, {8'h00, 2'(k), 6'h01});
         pulse(0, n, len);
         exp_acc += (k == 0) ? 16'h0001 : 16'(2 << k);
         rdchk(ADDR_ENERGY_ACC1, exp_acc);
      end
      // Drain one count per step; 1.5 intervals give one or two steps.
      for (int k = 0; k < 4; k++) begin
         rd(ADDR_ENERGY_ACC1, a0);
         wr(ADDR_ENERGY_CTRL, {8'h01, 2'b00, 2'(k), 4'h1});
         repeat ((3 << k) * TICK_CYC / 2) @(posedge mclk);
         wr(ADDR_ENERGY_CTRL, 16'h0001);
         rd(ADDR_ENERGY_ACC1, a1);
         chk(16'(a0 - a1 inside {16'h0001, 16'h0002}), 16'h0001);
      end
      chk(16'(a1 < exp_acc), 16'h0001);
      wr(ADDR_ENERGY_CTRL, 16'h0000);
      rdchk(ADDR_ENERGY_ACC1, 16'h0000);
      // Hitting the limit cuts the pulse short and starts the rest.
      wr(ADDR_ENERGY_CTRL, 16'h0001);
      wr(ADDR_ENERGY_LIMIT, 16'h0003);
      wr(ADDR_PULSE_DUR, 16'h0008);
      pulse(0, n, len);
      chk(16'(len <= 3 * TICK_CYC + 4), 16'h0001);
      rdchk(ADDR_ENERGY_ACC1, 16'h0000);
      pulse(1, n, len);
      @(posedge mclk);
      contact <= 2'b00;
      repeat (8) @(posedge mclk);
      contact <= 2'b01;
      repeat (2000) @(posedge mclk);
      chk({15'h0000, pulse_active[0]}, 16'h0000);
      rdchk(ADDR_ENERGY_ACC1, 16'h0000);
      repeat (12 * TICK_CYC) @(posedge mclk);
      wr(ADDR_ENERGY_LIMIT, 16'hffff);
      pulse(0, n, len);
      chk(16'(len > 7 * TICK_CYC), 16'h0001);
      close_out();
   end
endmodule : tb
